// ---- core/tssd_pkg.sv ----
/*
 package of the two-stage sinc decimator with gain correction:
 register offsets, field positions, reset values and filter constants.
 assumes a 32-bit axi4-lite register bus and up to eight channels.
*/
// Behaviour
// RL1 - two cascaded stages: dual_fourth_order_pair or fifth_plus_first_pair
// RL2 - total ratio is first times second ratio
// RL3 - second ratio above one only at 256
// RL4 - total ratio up to 256 bypasses stage two
// RL5 - no result after channel switch until settled
// RL6 - single-stage sinc4 gain from power-of-two rounding
// RL7 - two-stage gain is product of stage gains
// RL8 - each result scaled by channel correction coefficient
// RL9 - coefficient unity value is 0x00400000
// RL10 - software places sinc notch on interference
// RL11 - settings held per channel, eight channels
// RL12 - one corrected result per total ratio bits
package tssd_pkg;
   // number of conversion channels
   localparam int NUM_CH = 8;
   // register byte offsets
   localparam logic [7:0] OFS_CHCFG = 8'h00;   // 8 words, one per channel
   localparam logic [7:0] OFS_COEFF = 8'h20;   // 8 words, one per channel
   localparam logic [7:0] OFS_STATUS = 8'h40;
   localparam logic [7:0] OFS_RESULT = 8'h44;
   // channel configuration fields
   localparam int CFG_TYPE_BIT = 0;            // 0 dual fourth, 1 fifth plus first
   localparam int CFG_R1_LSB = 4;
   localparam int CFG_R1_W = 9;
   localparam int CFG_R2_LSB = 16;
   localparam int CFG_R2_W = 13;
   localparam int COEFF_W = 24;
   // status fields
   localparam int ST_SETTLED_BIT = 0;
   localparam int ST_RATIO_ERR_BIT = 1;
   localparam int ST_BYPASS_BIT = 2;
   localparam int ST_TYPE_BIT = 3;
   localparam int ST_CH_LSB = 4;
   // reset values
   localparam logic RST_TYPE = 1'b0;
   localparam logic [8:0] RST_R1 = 9'h100;
   localparam logic [12:0] RST_R2 = 13'h0001;
   localparam logic [23:0] COEFF_UNITY = 24'h400000;
   localparam int COEFF_FRAC = 22;             // unity is two to this power
   // filter constants
   localparam logic [8:0] FULL_R1 = 9'h100;    // only ratio that unlocks stage two
   localparam int SAMPLE_FRAC = 23;            // normalised full scale bits
   localparam int SAMPLE_W = 25;               // normalised sample width
   localparam int RESULT_W = 24;               // saturated result width
   localparam logic [2:0] ORD_DUAL_FIRST = 3'h4;
   localparam logic [2:0] ORD_DUAL_SECOND = 3'h4;
   localparam logic [2:0] ORD_FIFTH_FIRST = 3'h5;
   localparam logic [2:0] ORD_FIFTH_SECOND = 3'h1;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- core/tssd_decimator.sv ----
/*
 two-stage sinc decimation filter with per-channel ratios, filter type and
 gain correction, reached over an axi4-lite slave.
 assumes the modulator bitstream and the channel switch strobe are synchronous
 to aclk; new ratio and type settings take effect at the next channel switch, coefficients at once.
*/
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module tssd_decimator #(
   parameter int W1 = 42,   // stage one accumulator width
   parameter int W2 = 74    // stage two accumulator width
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // modulator bitstream
   input wire logic mod_bit,
   input wire logic mod_valid,
   // channel sequencer
   input wire logic [2:0] chan_sel,
   input wire logic chan_switch,
   // conversion result
   output logic [31:0] result_data,
   output logic [2:0] result_chan,
   output logic result_valid
);
   localparam int PW = W1 + tssd_pkg::SAMPLE_FRAC;   // stage one scaled width
   localparam int MW = tssd_pkg::SAMPLE_W + tssd_pkg::COEFF_W + 1;

   // all block state
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_full;
      logic [7:0] aw_addr;
      logic w_full;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [7:0] ch_type;
      logic [7:0][8:0] ch_r1;
      logic [7:0][12:0] ch_r2;
      logic [7:0][23:0] ch_coeff;
      logic [2:0] act_ch;
      logic act_type;
      logic [8:0] act_r1;
      logic [12:0] act_r2;
      logic [2:0] n1;
      logic [2:0] n2;
      logic [6:0] k1;
      logic [6:0] k2;
      logic ratio_err;
      logic [4:0][W1-1:0] i1;
      logic [4:0][W1-1:0] d1;
      logic [8:0] cnt1;
      logic [2:0] set1;
      logic [3:0][W2-1:0] i2;
      logic [3:0][W2-1:0] d2;
      logic [12:0] cnt2;
      logic [2:0] set2;
      logic settled;
      logic pend;
      logic [2:0] pend_ch;
      logic [tssd_pkg::SAMPLE_W-1:0] pend_val;
      logic res_valid;
      logic [2:0] res_ch;
      logic [31:0] res_data;
   } tssd_state_s;

   tssd_state_s st;
   tssd_state_s next_st;

   // base-two logarithm of r to the power n, rounded up, the hardware's scaling shift
   function automatic logic [6:0] tssd_ceil_bits(input logic [12:0] r, input logic [2:0] n);
      logic [63:0] p;
      logic [6:0] k;
      p = 64'h1;
      k = 7'h0;
      for (int j = 0; j < 5; j++) begin
         if (j < int'(n)) begin
            p = 64'(p * {51'h0, r});
         end
      end
      for (int j = 0; j < 63; j++) begin
         if ((64'h1 << j) < p) begin
            k = 7'(j + 1);
         end
      end
      return k;
   endfunction

   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] tssd_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return m;
   endfunction

   // outputs straight from state flops
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rresp = st.rresp;
   assign s_axi_rdata = st.rdata;
   assign result_data = st.res_data;
   assign result_chan = st.res_ch;
   assign result_valid = st.res_valid;

   // next-state logic of the whole block
   always_comb begin
      logic [5:0] widx;
      logic [5:0] ridx;
      logic [31:0] old;
      logic [31:0] nw;
      logic [31:0] rd;
      logic rok;
      logic [8:0] r1;
      logic [12:0] r2;
      logic tp;
      logic [2:0] o1;
      logic [2:0] o2;
      logic signed [W1-1:0] x;
      logic signed [W1-1:0] tap1;
      logic [4:0][W1-1:0] c1;
      logic ev1;
      logic signed [PW-1:0] s1w;
      logic [tssd_pkg::SAMPLE_W-1:0] s1;
      logic signed [W2-1:0] tap2;
      logic [3:0][W2-1:0] c2;
      logic ev2;
      logic signed [W2-1:0] s2w;
      logic signed [MW-1:0] prod;
      logic signed [MW-1:0] scaled;
      logic [23:0] sat;
      widx = 6'h0;
      ridx = 6'h0;
      old = 32'h0;
      nw = 32'h0;
      rd = 32'h0;
      rok = 1'b1;
      r1 = 9'h0;
      r2 = 13'h0;
      tp = 1'b0;
      o1 = 3'h0;
      o2 = 3'h0;
      x = '0;
      tap1 = '0;
      c1 = '0;
      ev1 = 1'b0;
      s1w = '0;
      s1 = '0;
      tap2 = '0;
      c2 = '0;
      ev2 = 1'b0;
      s2w = '0;
      prod = '0;
      scaled = '0;
      sat = 24'h0;
      next_st = st;

      // write address and data are taken independently, in either order
      if (st.awready && s_axi_awvalid) begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
         next_st.awready = 1'b0;
      end
      if (st.wready && s_axi_wvalid) begin
         next_st.w_full = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
         next_st.wready = 1'b0;
      end
      // register write once both halves are held
      if (st.aw_full && st.w_full && !st.bvalid) begin
         widx = st.aw_addr[7:2];
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = tssd_pkg::RESP_OKAY;
         if (widx < 6'(tssd_pkg::OFS_COEFF[7:2])) begin
            // channel configuration word
            old = 32'h0;
            old[tssd_pkg::CFG_TYPE_BIT] = st.ch_type[widx[2:0]];
            old[tssd_pkg::CFG_R1_LSB +: tssd_pkg::CFG_R1_W] = st.ch_r1[widx[2:0]];
            old[tssd_pkg::CFG_R2_LSB +: tssd_pkg::CFG_R2_W] = st.ch_r2[widx[2:0]];
            nw = tssd_merge(old, st.w_data, st.w_strb);
            next_st.ch_type[widx[2:0]] = nw[tssd_pkg::CFG_TYPE_BIT]; // RL11
            next_st.ch_r1[widx[2:0]] = nw[tssd_pkg::CFG_R1_LSB +: tssd_pkg::CFG_R1_W];
            next_st.ch_r2[widx[2:0]] = nw[tssd_pkg::CFG_R2_LSB +: tssd_pkg::CFG_R2_W];
         end else if (widx < 6'(tssd_pkg::OFS_STATUS[7:2])) begin
            // gain correction coefficient, unity at 0x00400000
            nw = tssd_merge({8'h0, st.ch_coeff[widx[2:0]]}, st.w_data, st.w_strb);
            next_st.ch_coeff[widx[2:0]] = nw[tssd_pkg::COEFF_W-1:0]; // RL9
         end else if (widx > 6'(tssd_pkg::OFS_RESULT[7:2])) begin
            // unmapped address
            next_st.bresp = tssd_pkg::RESP_SLVERR;
         end
      end
      // write response handshake reopens both channels
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
         next_st.awready = 1'b1;
         next_st.wready = 1'b1;
      end

      // read: address taken, data answered on the next edge
      if (st.arready && s_axi_arvalid) begin
         ridx = s_axi_araddr[7:2];
         if (ridx < 6'(tssd_pkg::OFS_COEFF[7:2])) begin
            rd[tssd_pkg::CFG_TYPE_BIT] = st.ch_type[ridx[2:0]];
            rd[tssd_pkg::CFG_R1_LSB +: tssd_pkg::CFG_R1_W] = st.ch_r1[ridx[2:0]];
            rd[tssd_pkg::CFG_R2_LSB +: tssd_pkg::CFG_R2_W] = st.ch_r2[ridx[2:0]];
         end else if (ridx < 6'(tssd_pkg::OFS_STATUS[7:2])) begin
            rd = {8'h0, st.ch_coeff[ridx[2:0]]};
         end else if (ridx == 6'(tssd_pkg::OFS_STATUS[7:2])) begin
            rd[tssd_pkg::ST_SETTLED_BIT] = st.settled;
            rd[tssd_pkg::ST_RATIO_ERR_BIT] = st.ratio_err;
            rd[tssd_pkg::ST_BYPASS_BIT] = (st.act_r2 == 13'h1);
            rd[tssd_pkg::ST_TYPE_BIT] = st.act_type;
            rd[tssd_pkg::ST_CH_LSB +: 3] = st.act_ch;
         end else if (ridx == 6'(tssd_pkg::OFS_RESULT[7:2])) begin
            rd = st.res_data;
         end else begin
            rok = 1'b0;
         end
         next_st.rdata = rd;
         next_st.rresp = rok ? tssd_pkg::RESP_OKAY : tssd_pkg::RESP_SLVERR;
         next_st.rvalid = 1'b1;
         next_st.arready = 1'b0;
      end
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
         next_st.arready = 1'b1;
      end

      // result strobe lasts one cycle
      next_st.res_valid = 1'b0;
      next_st.pend = 1'b0;

      if (chan_switch) begin
         // channel switch: load the channel's settings and restart the filter
         r1 = st.ch_r1[chan_sel];
         tp = st.ch_type[chan_sel];
         o1 = tp ? tssd_pkg::ORD_FIFTH_FIRST : tssd_pkg::ORD_DUAL_FIRST; // RL1
         o2 = tp ? tssd_pkg::ORD_FIFTH_SECOND : tssd_pkg::ORD_DUAL_SECOND; // RL1
         // stage two only unlocked at the full first ratio
         r2 = (r1 == tssd_pkg::FULL_R1) ? st.ch_r2[chan_sel] : 13'h1; // RL3
         next_st.ratio_err = (r1 != tssd_pkg::FULL_R1) && (st.ch_r2[chan_sel] > 13'h1); // RL3
         next_st.act_ch = chan_sel; // RL11
         next_st.act_type = tp;
         next_st.act_r1 = r1;
         next_st.act_r2 = (r2 == 13'h0) ? 13'h1 : r2;
         next_st.n1 = o1;
         next_st.n2 = o2;
         // scaling shifts set the documented passband gain of each stage
         next_st.k1 = tssd_ceil_bits({4'h0, r1}, o1); // RL6
         next_st.k2 = tssd_ceil_bits(r2, o2); // RL7
         next_st.i1 = '0;
         next_st.d1 = '0;
         next_st.i2 = '0;
         next_st.d2 = '0;
         next_st.cnt1 = 9'h0;
         next_st.cnt2 = 13'h0;
         next_st.set1 = 3'h0;
         next_st.set2 = 3'h0;
         next_st.settled = 1'b0; // RL5
      end else begin
         // stage one: integrators at the modulator rate
         if (mod_valid) begin
            x = mod_bit ? W1'(1) : -W1'(1);
            next_st.i1[0] = W1'(st.i1[0] + x);
            for (int j = 1; j < 5; j++) begin
               next_st.i1[j] = W1'(st.i1[j] + st.i1[j-1]);
            end
            ev1 = (st.cnt1 >= st.act_r1 - 9'h1);
            next_st.cnt1 = ev1 ? 9'h0 : 9'(st.cnt1 + 9'h1);
         end
         // stage one combs at the first decimation point
         if (ev1) begin
            tap1 = st.i1[st.n1 - 3'h1];
            c1[0] = W1'(tap1 - st.d1[0]);
            next_st.d1[0] = tap1;
            for (int j = 1; j < 5; j++) begin
               c1[j] = W1'(c1[j-1] - st.d1[j]);
               next_st.d1[j] = c1[j-1];
            end
            s1w = $signed({c1[st.n1 - 3'h1], {tssd_pkg::SAMPLE_FRAC{1'b0}}}) >>> st.k1;
            s1 = s1w[tssd_pkg::SAMPLE_W-1:0];
            if (st.set1 < st.n1) begin
               // comb history still holds pre-switch zeros
               next_st.set1 = 3'(st.set1 + 3'h1); // RL5
            end else if (st.act_r2 == 13'h1) begin
               // second ratio of one (total ratio is the first ratio, up to 511): stage one result goes straight out
               next_st.pend = 1'b1; // RL4
               next_st.pend_val = s1;
            end else begin
               // stage two integrators at the first-stage output rate
               next_st.i2[0] = W2'(st.i2[0] + W2'($signed(s1)));
               for (int j = 1; j < 4; j++) begin
                  next_st.i2[j] = W2'(st.i2[j] + st.i2[j-1]);
               end
               ev2 = (st.cnt2 >= st.act_r2 - 13'h1); // RL2
               next_st.cnt2 = ev2 ? 13'h0 : 13'(st.cnt2 + 13'h1);
            end
         end
         // stage two combs at the second decimation point
         if (ev2) begin
            tap2 = st.i2[st.n2 - 3'h1];
            c2[0] = W2'(tap2 - st.d2[0]);
            next_st.d2[0] = tap2;
            for (int j = 1; j < 4; j++) begin
               c2[j] = W2'(c2[j-1] - st.d2[j]);
               next_st.d2[j] = c2[j-1];
            end
            s2w = $signed(c2[st.n2 - 3'h1]) >>> st.k2; // RL7
            if (st.set2 < st.n2) begin
               next_st.set2 = 3'(st.set2 + 3'h1); // RL5
            end else begin
               next_st.pend = 1'b1;
               next_st.pend_val = s2w[tssd_pkg::SAMPLE_W-1:0];
            end
         end
      end
      next_st.pend_ch = st.act_ch;

      // gain correction and saturation of a finished sample
      if (st.pend && !chan_switch) begin
         prod = MW'($signed(st.pend_val)) *
                MW'($signed({1'b0, st.ch_coeff[st.pend_ch]})); // RL8
         scaled = prod >>> tssd_pkg::COEFF_FRAC; // RL9
         if (scaled > MW'(24'sh7fffff)) begin
            sat = 24'h7fffff;
         end else if (scaled < -MW'(25'sh0800000)) begin
            sat = 24'h800000;
         end else begin
            sat = scaled[tssd_pkg::RESULT_W-1:0];
         end
         next_st.res_data = {{8{sat[23]}}, sat};
         next_st.res_ch = st.pend_ch;
         next_st.res_valid = 1'b1; // RL12
         next_st.settled = 1'b1;
      end
   end

   // state register with synchronous reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.ch_type <= {8{tssd_pkg::RST_TYPE}};
         st.ch_r1 <= {8{tssd_pkg::RST_R1}};
         st.ch_r2 <= {8{tssd_pkg::RST_R2}};
         st.ch_coeff <= {8{tssd_pkg::COEFF_UNITY}};
         st.act_r1 <= tssd_pkg::RST_R1;
         st.act_r2 <= tssd_pkg::RST_R2;
         st.n1 <= tssd_pkg::ORD_DUAL_FIRST;
         st.n2 <= tssd_pkg::ORD_DUAL_SECOND;
         st.k1 <= 7'h20;
         st.k2 <= 7'h0;
      end else begin
         st <= next_st;
      end
   end
endmodule

// ---- verif/tssd_decimator_assertions.sv ----
/*
 port checker for the decimator: bus answers, result pulses, channel tags.
 assumes it is bound to tssd_decimator; reset is synchronous, active low.
*/
`timescale 1ns/1ps
module tssd_decimator_assertions (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // channel sequencer and results
   input wire logic [2:0] chan_sel,
   input wire logic chan_switch,
   input wire logic [31:0] result_data,
   input wire logic [2:0] result_chan,
   input wire logic result_valid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [2:0] act_ch; // channel loaded at the last switch
   // track the active channel
   always_ff @(posedge aclk) begin
      if (!aresetn) act_ch <= 3'h0;
      else if (chan_switch) act_ch <= chan_sel;
   end
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("no write response");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("no read data");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
   property p_res_pulse;
      result_valid |=> !result_valid;
   endproperty
   a_res_pulse: assert property (p_res_pulse) else $error("result strobe too long");
   property p_settle_quiet;
      chan_switch |=> !result_valid [*8];
   endproperty
   a_settle_quiet: assert property (p_settle_quiet) else $error("result before settling");
   property p_res_hold;
      !result_valid |-> $stable(result_data) && $stable(result_chan);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result changed unflagged");
   property p_res_chan;
      result_valid |-> result_chan == act_ch;
   endproperty
   a_res_chan: assert property (p_res_chan) else $error("result channel wrong");
   c_result: cover property (result_valid);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_switch: cover property (chan_switch);
endmodule
bind tssd_decimator tssd_decimator_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .chan_sel, .chan_switch, .result_data, .result_chan, .result_valid);

// ---- verif/tssd_mod_source.sv ----
/*
 modulator bitstream model: a constant bit level, one bit a cycle or every
 other cycle. assumes run, level and slow change just after a clock edge.
*/
`timescale 1ns/1ps
module tssd_mod_source (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic run,
   input wire logic level,
   input wire logic slow,
   // bitstream
   output logic mod_bit,
   output logic mod_valid
);
   logic ph; // phase for the slow rate
   // bit pacing; idle line toggles so no stale bit looks valid
   always @(posedge aclk) begin
      if (!aresetn) begin
         mod_valid <= 1'h0;
         mod_bit <= 1'h0;
         ph <= 1'h0;
      end else begin
         ph <= ~ph;
         if (run && (!slow || ph)) begin
            mod_valid <= 1'h1;
            mod_bit <= level;
         end else begin
            mod_valid <= 1'h0;
            mod_bit <= ~mod_bit;
         end
      end
   end
endmodule

// ---- verif/two_stage_sinc_decimator_gain_corr_tb.sv ----
/*
 bench for the decimator: register access over the bus, per-channel runs.
 assumes the modulator model drives the bitstream; 10 MHz clock.
*/
`timescale 1ns/1ps
module two_stage_sinc_decimator_gain_corr_tb;
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, result_data;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic mod_bit, mod_valid, run = 1'h0, level = 1'h0, slow = 1'h0;
   logic [2:0] chan_sel = 3'h0, result_chan;
   logic chan_switch = 1'h0, result_valid;
   logic [31:0] d;
   int fails = 0, total_checks = 0;
   // 100 ns clock
   initial begin
      forever #50 aclk = ~aclk;
   end
   tssd_decimator i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mod_bit, .mod_valid, .chan_sel,
      .chan_switch, .result_data, .result_chan, .result_valid);
   tssd_mod_source i_src (.aclk, .aresetn, .run, .level, .slow, .mod_bit, .mod_valid);
   // compare and count
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // cut a hung wait short
   task automatic guard(input int n);
      if (n > 20000) begin
         fails++;
         $display("[FAIL] wait expected answer seen timeout");
         summarize();
      end
   endtask
   // bus write: address and data offered together
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
         n++;
         guard(n);
      end while (s_axi_bvalid !== 1'h1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   // bus read
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
         n++;
         guard(n);
      end while (s_axi_rvalid !== 1'h1);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   // write expecting an okay answer
   task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] rs;
      bus_wr(a, v, rs);
      check("bresp", 32'(rs), 32'(tssd_pkg::RESP_OKAY));
   endtask
   // read and compare
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic [1:0] rs;
      bus_rd(a, v, rs);
      check("rresp", 32'(rs), 32'(tssd_pkg::RESP_OKAY));
      check(what, v, exp);
   endtask
   // wait for a result, counting modulator bits meanwhile
   task automatic wait_res(output int nb);
      int n;
      n = 0;
      nb = 0;
      do begin
         @(posedge aclk);
         if (mod_valid) nb++;
         n++;
         guard(n);
      end while (result_valid !== 1'h1);
   endtask
   // configure a channel, switch to it, check two results and status
   task automatic run_case(input logic [2:0] ch, input logic [31:0] cfg, input logic [31:0] cf,
      input logic lvl, input logic slw, input logic [31:0] exp, input int tot, input int st_b,
      input logic [3:0] st);
      int nb;
      wr_ok({3'h0, ch, 2'h0}, cfg);
      wr_ok(tssd_pkg::OFS_COEFF + {3'h0, ch, 2'h0}, cf);
      rd_chk("cfg", {3'h0, ch, 2'h0}, cfg);
      @(posedge aclk);
      chan_sel <= ch;
      chan_switch <= 1'h1;
      @(posedge aclk);
      chan_switch <= 1'h0;
      run <= 1'h1;
      level <= lvl;
      slow <= slw;
      wait_res(nb);
      check("settle", 32'(nb >= st_b && nb <= st_b + 3), 32'h1);
      check("first", result_data, exp);
      check("chan", 32'(result_chan), 32'(ch));
      wait_res(nb);
      check("period", 32'(nb), 32'(tot));
      check("second", result_data, exp);
      rd_chk("result", tssd_pkg::OFS_RESULT, exp);
      rd_chk("status", tssd_pkg::OFS_STATUS, {25'h0, ch, st});
      run <= 1'h0;
      $display("test channel %0d done", ch);
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      rd_chk("cfg_reset", 8'h14, 32'h00011000);
      rd_chk("coeff_reset", 8'h34, {8'h0, tssd_pkg::COEFF_UNITY});
      // byte strobes: only the low byte of the coefficient is replaced
      s_axi_wstrb <= 4'h1;
      wr_ok(8'h34, 32'h000000ff);
      s_axi_wstrb <= 4'hf;
      rd_chk("coeff_strobe", 8'h34, 32'h004000ff);
      bus_wr(8'h48, 32'h1, r);
      check("wr_unmapped", 32'(r), 32'(tssd_pkg::RESP_SLVERR));
      bus_rd(8'h48, d, r);
      check("rd_unmapped", 32'(r), 32'(tssd_pkg::RESP_SLVERR));
      check("rd_unmapped_data", d, 32'h0);
      $display("test register access done");
      run_case(3'h0, 32'h00010200, 32'h00200000, 1'h1, 1'h0, 32'h00400000, 32, 160, 4'h5);
      run_case(3'h1, 32'h00010300, 32'h00400000, 1'h1, 1'h0, 32'h00510000, 48, 240, 4'h5);
      run_case(3'h2, 32'h00031001, 32'h002aaaaa, 1'h1, 1'h0, 32'h003fffff, 768, 2816, 4'h9);
      run_case(3'h3, 32'h00031000, 32'h00400000, 1'h0, 1'h1, 32'hffaf0000, 768, 4864, 4'h1);
      run_case(3'h4, 32'h00030200, 32'h00400000, 1'h1, 1'h0, 32'h007fffff, 32, 160, 4'h7);
      run_case(3'h7, 32'h00010201, 32'h00100000, 1'h1, 1'h0, 32'h00200000, 32, 192, 4'hd);
      summarize();
   end
endmodule
